// ==== src/omirm_pkg.sv ====
// Package with register map, field layout, mode codes and timing for the output mux.
package omirm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [6:0] OMIRM_ADDR_MODE = 7'h02;
  localparam logic [6:0] OMIRM_ADDR_ROUTE = 7'h03;
  localparam logic [6:0] OMIRM_ADDR_IDX = 7'h04;
  localparam logic [6:0] OMIRM_ADDR_SC = 7'h05;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OMIRM_ENABLE_BIT = 7;
  localparam int OMIRM_LOAD_LSB = 0;
  localparam int OMIRM_LOAD_MSB = 3;
  localparam int OMIRM_VOS_LSB = 4;
  localparam int OMIRM_VOS_MSB = 5;
  localparam int OMIRM_BIAS_BIT = 6;
  localparam int OMIRM_INV_BIT = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [6:0] OMIRM_CTL_RST = 7'h00;
  localparam logic OMIRM_EN_RST = 1'h0;
  localparam logic [6:0] OMIRM_ROUTE_RST = 7'h00;
  localparam logic [6:0] OMIRM_IDX_RST = 7'h00;
  localparam logic [6:0] OMIRM_SC_RST = 7'h00;
  // ----------------------------------------
  // Operating modes and codes
  // ----------------------------------------
  localparam logic [3:0] OMIRM_MODE_QUAD = 4'h0;
  localparam logic [3:0] OMIRM_MODE_CNT = 4'hF;
  localparam logic [3:0] OMIRM_MODE_CAL2 = 4'h2;
  localparam logic [3:0] OMIRM_MODE_PINCHK = 4'h6;
  localparam logic [3:0] OMIRM_MODE_CAL3 = 4'h7;
  localparam logic [3:0] OMIRM_MODE_SYST = 4'hB;
  localparam logic [6:0] OMIRM_ROUTE_BYPASS = 7'h40;
  localparam logic [1:0] OMIRM_VOS_TRACK = 2'h3;
  localparam logic [2:0] OMIRM_PIN_X1 = 3'h1;
  localparam logic [2:0] OMIRM_PIN_X2 = 3'h2;
  localparam logic [2:0] OMIRM_PIN_X3 = 3'h3;
  localparam logic [2:0] OMIRM_PIN_X4 = 3'h4;
  localparam logic [2:0] OMIRM_PIN_X5 = 3'h5;
  localparam logic [2:0] OMIRM_PIN_X6 = 3'h6;
  localparam logic [1:0] OMIRM_IDX_CNT_VALID = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int OMIRM_CLK_NS = 40;
  localparam int OMIRM_PULSE_LOW_NS = 40;
  localparam int OMIRM_PULSE_LOW_CYC_I = (OMIRM_PULSE_LOW_NS + OMIRM_CLK_NS - 1) / OMIRM_CLK_NS;
  localparam logic [3:0] OMIRM_PULSE_LOW_CYC = 4'(OMIRM_PULSE_LOW_CYC_I);
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OMIRM_IDLE = 2'h0,
    OMIRM_SETUP = 2'h1,
    OMIRM_PULSE = 2'h3,
    OMIRM_REC = 2'h2
  } omirm_cnt_state_t;
endpackage

// ==== src/omirm_cnt_if.sv ====
// Interface between the pin mux and its count clock generator.
`timescale 1ns/1ps
interface omirm_cnt_if;
  logic step_up;
  logic step_dn;
  logic dir;
  logic clk_dn_n;
  logic clk_up_n;
  logic clk_all_n;
  modport gen (input step_up, input step_dn, output dir, output clk_dn_n, output clk_up_n,
    output clk_all_n);
  modport use_side (output step_up, output step_dn, input dir, input clk_dn_n,
    input clk_up_n, input clk_all_n);
endinterface

// ==== src/omirm_cnt_gen.sv ====
// Count clock generator for the up/down counter mode.
`timescale 1ns/1ps
module omirm_cnt_gen
  import omirm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  omirm_cnt_if.gen cnt
);
  typedef struct packed {
    omirm_cnt_state_t st;
    logic [3:0] cnt;
    logic dir;
    logic clk_dn_n;
    logic clk_up_n;
    logic clk_all_n;
  } omirm_cg_t;
  omirm_cg_t cur_reg;
  omirm_cg_t cur_next;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    cur_next = cur_reg;
    case (cur_reg.st)
      OMIRM_IDLE: begin
        if (cnt.step_up ^ cnt.step_dn) begin
          cur_next.dir = cnt.step_dn;
          cur_next.st = OMIRM_SETUP;
        end
      end
      OMIRM_SETUP: begin
        cur_next.clk_all_n = 1'b0;
        cur_next.clk_dn_n = ~cur_reg.dir;
        cur_next.clk_up_n = cur_reg.dir;
        cur_next.cnt = 4'h1;
        cur_next.st = OMIRM_PULSE;
      end
      OMIRM_PULSE: begin
        if (cur_reg.cnt >= OMIRM_PULSE_LOW_CYC) begin
          cur_next.clk_all_n = 1'b1;
          cur_next.clk_dn_n = 1'b1;
          cur_next.clk_up_n = 1'b1;
          cur_next.st = OMIRM_REC;
        end else begin
          cur_next.cnt = cur_reg.cnt + 4'h1;
        end
      end
      OMIRM_REC: cur_next.st = OMIRM_IDLE;
      default: cur_next.st = OMIRM_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg <= '{st: OMIRM_IDLE, cnt: 4'h0, dir: 1'b0, clk_dn_n: 1'b1, clk_up_n: 1'b1,
        clk_all_n: 1'b1};
    end else begin
      cur_reg <= cur_next;
    end
  end
  assign cnt.dir = cur_reg.dir;
  assign cnt.clk_dn_n = cur_reg.clk_dn_n;
  assign cnt.clk_up_n = cur_reg.clk_up_n;
  assign cnt.clk_all_n = cur_reg.clk_all_n;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_dir_first;
    @(posedge core_clk) disable iff (!rst_b)
    (cur_reg.st == OMIRM_IDLE && cnt.step_up && !cnt.step_dn) |=>
      !cur_reg.dir ##1 (!cur_reg.clk_up_n && !cur_reg.clk_all_n && cur_reg.clk_dn_n);
  endproperty
  a_dir_first: assert property (p_dir_first) else $error("Up step did not pulse in time.");
  property p_dir_stable;
    @(posedge core_clk) disable iff (!rst_b)
    $fell(cur_reg.clk_all_n) |-> $stable(cur_reg.dir) && (cur_reg.clk_dn_n != cur_reg.dir);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("Direction moved at pulse.");
  property p_cov_pulse;
    @(posedge core_clk) disable iff (!rst_b) $rose(cur_reg.clk_dn_n);
  endproperty
  c_cov_pulse: cover property (p_cov_pulse);
endmodule // omirm_cnt_gen

// ==== src/omirm_mux.sv ====
// Output mode mux and input route configuration for the interpolator pins.
// Operation
// - Mode field decodes quadrature, counter, system test and input check.
// - Line drivers run only in quadrature and counter modes; polarity guard also runs in CAL3 and system test.
// - Quadrature mode puts A, B and the configured index on the three pairs.
// - Each inverted quadrature pin is the complement of its true pin.
// - Counter mode drives down, up and combined count clocks on first pins.
// - Direction output is low for up and high for down.
// - Counter clear output is high while the index position is reached.
// - Load strobe output is low while the index position is reached.
// - Reduced gain calibration routes the tracking potentials when source is three.
// - System test shows the four calibration probes on the A and B pairs.
// - System test drives the ungated index on the index true pin.
// - Line count flag is low while checking and high once finished.
// - Line count error is valid only after the second enabled index.
// - Index inputs always come from input pins one and two.
// - Routing low bits select the sine and cosine pin pairs.
// - Load field selects current resistance or voltage divider or high impedance.
// - Bias bit selects the higher or lower input reference level.
`timescale 1ns/1ps
module omirm_mux
  import omirm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic trk_a,
  input wire logic trk_b,
  input wire logic idx_gated,
  input wire logic idx_raw,
  input wire logic idx_enable,
  input wire logic step_up,
  input wire logic step_dn,
  input wire logic ch1_offset_probe,
  input wire logic quadrature_phase_probe,
  input wire logic ch2_offset_probe,
  input wire logic amplitude_balance_probe,
  input wire logic line_count_done,
  input wire logic line_count_error,
  input wire logic fault_in,
  output logic a_track_true_pin,
  output logic a_track_inverted_pin,
  output logic b_track_true_pin,
  output logic b_track_inverted_pin,
  output logic index_true_pin,
  output logic index_inverted_pin,
  output logic pin_oe,
  output logic line_driver_en,
  output logic fault_pin,
  output logic potential_to_index,
  output logic pin_bypass_en,
  output logic [2:0] sin_p_sel,
  output logic [2:0] sin_n_sel,
  output logic [2:0] cos_p_sel,
  output logic [2:0] cos_n_sel,
  output logic [2:0] idx_p_sel,
  output logic [2:0] idx_n_sel,
  output logic idx_current_mode,
  output logic [1:0] idx_res_sel,
  output logic idx_divider_en,
  output logic index_ref_level,
  output logic sc_current_mode,
  output logic [1:0] sc_res_sel,
  output logic sc_divider_en,
  output logic sincos_ref_level
);
  typedef struct packed {
    logic [6:0] ctl;
    logic en;
    logic [6:0] route;
    logic [6:0] idx_cfg;
    logic [6:0] sc_cfg;
    logic [7:0] rdata;
    logic [5:0] pins;
    logic oe;
    logic drv;
    logic fault;
    logic vdc;
    logic byp;
    logic idx_prev;
    logic [1:0] idx_cnt;
    logic [11:0] sc_sel;
    logic [5:0] ix_sel;
    logic [3:0] ix_load;
    logic [3:0] sc_load;
  } omirm_st_t;

  omirm_st_t cur_reg;
  omirm_st_t cur_next;
  logic [3:0] mode;
  logic is_quad;
  logic is_cnt;
  logic is_syst;
  omirm_cnt_if cnt_bus ();

  // ----------------------------------------
  // Count clock generator
  // ----------------------------------------
  assign cnt_bus.step_up = step_up;
  assign cnt_bus.step_dn = step_dn;
  omirm_cnt_gen u_cnt_gen (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cnt(cnt_bus.gen)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign mode = cur_reg.ctl[3:0];
  assign is_quad = cur_reg.en && (mode == OMIRM_MODE_QUAD);
  assign is_cnt = cur_reg.en && (mode == OMIRM_MODE_CNT);
  assign is_syst = cur_reg.en && (mode == OMIRM_MODE_SYST);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    cur_next = cur_reg;
    // Register writes; mode bits only change while the device is in standby.
    if (cfg_wr) begin
      case (cfg_addr)
        OMIRM_ADDR_MODE: begin
          if (!cur_reg.en) begin
            cur_next.ctl = cfg_wdata[6:0];
          end
          cur_next.en = cfg_wdata[OMIRM_ENABLE_BIT];
        end
        OMIRM_ADDR_ROUTE: cur_next.route = cfg_wdata[6:0];
        OMIRM_ADDR_IDX: cur_next.idx_cfg = cfg_wdata[6:0];
        OMIRM_ADDR_SC: cur_next.sc_cfg = cfg_wdata[6:0];
        default: cur_next.ctl = cur_reg.ctl;
      endcase
    end
    // Read data; the enable bit is write only and reads as zero.
    case (cfg_addr)
      OMIRM_ADDR_MODE: cur_next.rdata = {1'b0, cur_reg.ctl};
      OMIRM_ADDR_ROUTE: cur_next.rdata = {1'b0, cur_reg.route};
      OMIRM_ADDR_IDX: cur_next.rdata = {1'b0, cur_reg.idx_cfg};
      OMIRM_ADDR_SC: cur_next.rdata = {1'b0, cur_reg.sc_cfg};
      default: cur_next.rdata = 8'h00;
    endcase
    // Output pins from bit 5 down: A true, A inverted, B true, B inverted, index true, inverted.
    cur_next.pins = 6'h00;
    if (is_quad) begin
      cur_next.pins = {trk_a, ~trk_a, trk_b, ~trk_b, idx_gated, ~idx_gated};
    end else if (is_cnt) begin
      cur_next.pins = {cnt_bus.clk_dn_n, cnt_bus.clk_up_n, cnt_bus.clk_all_n,
        cnt_bus.dir,
        idx_gated,
        ~idx_gated};
    end else if (is_syst) begin
      cur_next.pins = {ch1_offset_probe, quadrature_phase_probe,
        ch2_offset_probe, amplitude_balance_probe,
        idx_raw,
        line_count_done};
    end
    cur_next.oe = is_quad || is_cnt || is_syst;
    cur_next.drv = is_quad || is_cnt;
    // Index events seen while enabled, saturating at two.
    cur_next.idx_prev = idx_raw;
    if (!idx_enable || !is_syst) begin
      cur_next.idx_cnt = 2'h0;
    end else if (idx_raw && !cur_reg.idx_prev && cur_reg.idx_cnt != OMIRM_IDX_CNT_VALID) begin
      cur_next.idx_cnt = cur_reg.idx_cnt + 2'h1;
    end
    cur_next.fault = 1'b0;
    if (is_quad || is_cnt || (cur_reg.en && mode == OMIRM_MODE_CAL3)) begin
      cur_next.fault = fault_in;
    end else if (is_syst) begin
      cur_next.fault = fault_in ||
        (line_count_error && cur_reg.idx_cnt == OMIRM_IDX_CNT_VALID);
    end
    cur_next.vdc = cur_reg.en && mode == OMIRM_MODE_CAL2 &&
      cur_reg.sc_cfg[OMIRM_VOS_MSB:OMIRM_VOS_LSB] == OMIRM_VOS_TRACK;
    cur_next.byp = cur_reg.en && mode == OMIRM_MODE_PINCHK &&
      cur_reg.route == OMIRM_ROUTE_BYPASS;
    // Input routing of the sine and cosine pairs.
    case (cur_reg.route[2:0])
      3'h2: cur_next.sc_sel = {OMIRM_PIN_X4, OMIRM_PIN_X5, OMIRM_PIN_X3, OMIRM_PIN_X6};
      3'h3: cur_next.sc_sel = {OMIRM_PIN_X4, OMIRM_PIN_X3, OMIRM_PIN_X5, OMIRM_PIN_X6};
      3'h4: cur_next.sc_sel = {OMIRM_PIN_X4, OMIRM_PIN_X2, OMIRM_PIN_X3, OMIRM_PIN_X2};
      3'h7: cur_next.sc_sel = {OMIRM_PIN_X4, OMIRM_PIN_X2, OMIRM_PIN_X5, OMIRM_PIN_X2};
      default: cur_next.sc_sel = {OMIRM_PIN_X4, OMIRM_PIN_X6, OMIRM_PIN_X3, OMIRM_PIN_X5};
    endcase
    // The index pair is fixed; bit three only swaps its polarity.
    if (cur_reg.route[OMIRM_INV_BIT]) begin
      cur_next.ix_sel = {OMIRM_PIN_X2, OMIRM_PIN_X1};
    end else begin
      cur_next.ix_sel = {OMIRM_PIN_X1, OMIRM_PIN_X2};
    end
    cur_next.ix_load = cur_reg.idx_cfg[OMIRM_LOAD_MSB:OMIRM_LOAD_LSB];
    cur_next.sc_load = cur_reg.sc_cfg[OMIRM_LOAD_MSB:OMIRM_LOAD_LSB];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg <= '0;
      cur_reg.ctl <= OMIRM_CTL_RST;
      cur_reg.en <= OMIRM_EN_RST;
      cur_reg.route <= OMIRM_ROUTE_RST;
      cur_reg.idx_cfg <= OMIRM_IDX_RST;
      cur_reg.sc_cfg <= OMIRM_SC_RST;
      cur_reg.sc_sel <= {OMIRM_PIN_X4, OMIRM_PIN_X6, OMIRM_PIN_X3, OMIRM_PIN_X5};
      cur_reg.ix_sel <= {OMIRM_PIN_X1, OMIRM_PIN_X2};
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cfg_rdata = cur_reg.rdata;
  assign a_track_true_pin = cur_reg.pins[5];
  assign a_track_inverted_pin = cur_reg.pins[4];
  assign b_track_true_pin = cur_reg.pins[3];
  assign b_track_inverted_pin = cur_reg.pins[2];
  assign index_true_pin = cur_reg.pins[1];
  assign index_inverted_pin = cur_reg.pins[0];
  assign pin_oe = cur_reg.oe;
  assign line_driver_en = cur_reg.drv;
  assign fault_pin = cur_reg.fault;
  assign potential_to_index = cur_reg.vdc;
  assign pin_bypass_en = cur_reg.byp;
  assign sin_p_sel = cur_reg.sc_sel[11:9];
  assign sin_n_sel = cur_reg.sc_sel[8:6];
  assign cos_p_sel = cur_reg.sc_sel[5:3];
  assign cos_n_sel = cur_reg.sc_sel[2:0];
  assign idx_p_sel = cur_reg.ix_sel[5:3];
  assign idx_n_sel = cur_reg.ix_sel[2:0];
  assign idx_current_mode = ~cur_reg.ix_load[0];
  assign idx_res_sel = cur_reg.ix_load[2:1];
  assign idx_divider_en = cur_reg.ix_load[0] & cur_reg.ix_load[3];
  assign index_ref_level = cur_reg.idx_cfg[OMIRM_BIAS_BIT];
  assign sc_current_mode = ~cur_reg.sc_load[0];
  assign sc_res_sel = cur_reg.sc_load[2:1];
  assign sc_divider_en = cur_reg.sc_load[0] & cur_reg.sc_load[3];
  assign sincos_ref_level = cur_reg.sc_cfg[OMIRM_BIAS_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_drv_modes;
    @(posedge core_clk) disable iff (!rst_b)
    line_driver_en |-> $past(is_quad || is_cnt);
  endproperty
  a_drv_modes: assert property (p_drv_modes) else $error("Drivers on in wrong mode.");

  property p_quad_track;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_quad) |-> a_track_true_pin == $past(trk_a) && b_track_true_pin == $past(trk_b);
  endproperty
  a_quad_track: assert property (p_quad_track) else $error("Quadrature tracks wrong.");

  property p_quad_comp;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_quad) |-> a_track_inverted_pin == !a_track_true_pin &&
      b_track_inverted_pin == !b_track_true_pin && index_inverted_pin == !index_true_pin;
  endproperty
  a_quad_comp: assert property (p_quad_comp) else $error("Inverted pin not complement.");

  property p_cnt_index;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_cnt) |-> index_true_pin == $past(idx_gated) && index_inverted_pin == !$past(idx_gated);
  endproperty
  a_cnt_index: assert property (p_cnt_index) else $error("Clear or load strobe wrong.");

  property p_syst_index;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_syst) |-> index_true_pin == $past(idx_raw) &&
      index_inverted_pin == $past(line_count_done) && a_track_true_pin == $past(ch1_offset_probe);
  endproperty
  a_syst_index: assert property (p_syst_index) else $error("System test pins wrong.");

  property p_lc_valid;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_syst && !fault_in && cur_reg.idx_cnt != OMIRM_IDX_CNT_VALID) |-> !fault_pin;
  endproperty
  a_lc_valid: assert property (p_lc_valid) else $error("Early line count fault.");

  property p_route_three;
    @(posedge core_clk) disable iff (!rst_b)
    $past(cur_reg.route[2:0] == 3'h3) |-> sin_n_sel == OMIRM_PIN_X3 && cos_p_sel == OMIRM_PIN_X5;
  endproperty
  a_route_three: assert property (p_route_three) else $error("Route code three wrong.");

  property p_vdc_route;
    @(posedge core_clk) disable iff (!rst_b)
    potential_to_index |-> $past(mode == OMIRM_MODE_CAL2 &&
      cur_reg.sc_cfg[OMIRM_VOS_MSB:OMIRM_VOS_LSB] == OMIRM_VOS_TRACK);
  endproperty
  a_vdc_route: assert property (p_vdc_route) else $error("Potentials routed wrongly.");

  property p_cnt_clocks;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_cnt) |-> {a_track_true_pin, a_track_inverted_pin, b_track_true_pin,
      b_track_inverted_pin} == $past({cnt_bus.clk_dn_n, cnt_bus.clk_up_n,
      cnt_bus.clk_all_n, cnt_bus.dir});
  endproperty
  a_cnt_clocks: assert property (p_cnt_clocks) else $error("Count clock pins wrong.");

  property p_syst_probes;
    @(posedge core_clk) disable iff (!rst_b)
    $past(is_syst) |-> {a_track_inverted_pin, b_track_true_pin, b_track_inverted_pin} ==
      $past({quadrature_phase_probe, ch2_offset_probe, amplitude_balance_probe});
  endproperty
  a_syst_probes: assert property (p_syst_probes) else $error("Probe pins wrong.");

  property p_idx_fixed;
    @(posedge core_clk) disable iff (!rst_b)
    (idx_p_sel == OMIRM_PIN_X1 && idx_n_sel == OMIRM_PIN_X2) ||
      (idx_p_sel == OMIRM_PIN_X2 && idx_n_sel == OMIRM_PIN_X1);
  endproperty
  a_idx_fixed: assert property (p_idx_fixed) else $error("Index pins moved.");

  property p_cov_quad;
    @(posedge core_clk) disable iff (!rst_b) line_driver_en && $past(is_quad);
  endproperty
  c_cov_quad: cover property (p_cov_quad);

  property p_cov_cnt;
    @(posedge core_clk) disable iff (!rst_b) $past(is_cnt) && $fell(b_track_true_pin);
  endproperty
  c_cov_cnt: cover property (p_cov_cnt);

  property p_cov_lc;
    @(posedge core_clk) disable iff (!rst_b) $past(is_syst) && fault_pin;
  endproperty
  c_cov_lc: cover property (p_cov_lc);
endmodule // omirm_mux

// ==== verif/omirm_counter_model.sv ====
// Behavioural up/down counter that stands on the output pins in counter mode.
`timescale 1ns/1ps
module omirm_counter_model (
  input wire logic count_dn_clk,
  input wire logic count_up_clk,
  input wire logic count_clk,
  input wire logic direction,
  input wire logic clear,
  input wire logic load_n,
  output int up_seen,
  output int dn_seen,
  output int net_seen,
  output int dir_faults
);
  logic dir_at_fall;
  initial begin
    up_seen = 0;
    dn_seen = 0;
    net_seen = 0;
    dir_faults = 0;
    dir_at_fall = 1'b0;
  end
  // Separate up and down clocks, held off while clear or load is active.
  always @(posedge count_up_clk) if (!clear && load_n) up_seen += 1;
  always @(posedge count_dn_clk) if (!clear && load_n) dn_seen += 1;
  always @(negedge count_clk) dir_at_fall = direction;
  // Combined clock counts by direction, which must not move during the pulse.
  always @(posedge count_clk) begin
    if (direction !== dir_at_fall) dir_faults += 1;
    if (!clear && load_n) net_seen += direction ? -1 : 1;
  end
endmodule // omirm_counter_model

// ==== verif/omirm_mux_tb.sv ====
// Self-checking testbench for the output mode mux and input route block.
`timescale 1ns/1ps
module omirm_mux_tb;
  import omirm_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0;
  logic [6:0] cfg_addr = 7'h00;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
  logic trk_a = 1'b0, trk_b = 1'b0, idx_gated = 1'b0, idx_raw = 1'b0, idx_enable = 1'b0;
  logic step_up = 1'b0, step_dn = 1'b0, line_count_done = 1'b0, line_count_error = 1'b0;
  logic fault_in = 1'b0;
  logic [3:0] probes = 4'h0;
  logic a_track_true_pin, a_track_inverted_pin, b_track_true_pin, b_track_inverted_pin;
  logic index_true_pin, index_inverted_pin, pin_oe, line_driver_en, fault_pin;
  logic potential_to_index, pin_bypass_en, idx_current_mode, idx_divider_en, index_ref_level;
  logic sc_current_mode, sc_divider_en, sincos_ref_level;
  logic [2:0] sin_p_sel, sin_n_sel, cos_p_sel, cos_n_sel, idx_p_sel, idx_n_sel;
  logic [1:0] idx_res_sel, sc_res_sel;
  logic [5:0] pins;
  int up_seen, dn_seen, net_seen, dir_faults, err_count = 0, checks_done = 0;
  assign pins = {a_track_true_pin, a_track_inverted_pin, b_track_true_pin,
    b_track_inverted_pin, index_true_pin, index_inverted_pin};
  always #20 core_clk = ~core_clk;
  omirm_mux DUT (.core_clk, .rst_b, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .trk_a, .trk_b,
    .idx_gated, .idx_raw, .idx_enable, .step_up, .step_dn, .ch1_offset_probe(probes[3]),
    .quadrature_phase_probe(probes[2]), .ch2_offset_probe(probes[1]),
    .amplitude_balance_probe(probes[0]), .line_count_done, .line_count_error, .fault_in,
    .a_track_true_pin, .a_track_inverted_pin, .b_track_true_pin, .b_track_inverted_pin,
    .index_true_pin, .index_inverted_pin, .pin_oe, .line_driver_en, .fault_pin,
    .potential_to_index, .pin_bypass_en, .sin_p_sel, .sin_n_sel, .cos_p_sel, .cos_n_sel,
    .idx_p_sel, .idx_n_sel, .idx_current_mode, .idx_res_sel, .idx_divider_en, .index_ref_level,
    .sc_current_mode, .sc_res_sel, .sc_divider_en, .sincos_ref_level);
  omirm_counter_model partner (.count_dn_clk(a_track_true_pin),
    .count_up_clk(a_track_inverted_pin), .count_clk(b_track_true_pin),
    .direction(b_track_inverted_pin), .clear(index_true_pin), .load_n(index_inverted_pin),
    .up_seen, .dn_seen, .net_seen, .dir_faults);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    cfg_addr <= a;
    wait_cyc(2);
    chk(16'(cfg_rdata), 16'(exp));
  endtask
  task automatic set_mode(input logic [3:0] m);
    wr(OMIRM_ADDR_MODE, {4'h0, m});
    wr(OMIRM_ADDR_MODE, {4'h0, m});
    wr(OMIRM_ADDR_MODE, {4'h8, m});
    wait_cyc(2);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    chk(16'({idx_p_sel, idx_n_sel}), 16'h000A);
    chk(16'({sin_p_sel, sin_n_sel, cos_p_sel, cos_n_sel}), 16'h099D);
    chk(16'({pins, pin_oe, line_driver_en, fault_pin, cfg_rdata}), 16'h0000);
    chk(16'({idx_current_mode, sc_current_mode, index_ref_level, sincos_ref_level}), 16'hC);
  endtask
  task automatic test_quad;
    set_mode(OMIRM_MODE_QUAD);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {trk_a, trk_b, idx_gated} <= i[2:0];
      wait_cyc(1);
      chk(16'(pins), 16'({i[2], !i[2], i[1], !i[1], i[0], !i[0]}));
      chk(16'({pin_oe, line_driver_en}), 16'h3);
    end
    rd_chk(OMIRM_ADDR_MODE, 8'h00);
  endtask
  task automatic test_counter;
    logic [1:0] seq [5] = '{2'b10, 2'b10, 2'b01, 2'b10, 2'b11};
    int ub, db, nb, fb;
    set_mode(OMIRM_MODE_CNT);
    chk(16'({pin_oe, line_driver_en}), 16'h3);
    @(posedge core_clk);
    idx_gated <= 1'b1;
    wait_cyc(2);
    chk(16'({index_true_pin, index_inverted_pin}), 16'h2);
    @(posedge core_clk);
    idx_gated <= 1'b0;
    wait_cyc(2);
    chk(16'({index_true_pin, index_inverted_pin}), 16'h1);
    {ub, db, nb, fb} = {up_seen, dn_seen, net_seen, dir_faults};
    for (int k = 0; k < 5; k++) begin
      @(posedge core_clk);
      {step_up, step_dn} <= seq[k];
      @(posedge core_clk);
      {step_up, step_dn} <= 2'b00;
      wait_cyc(6);
      chk(16'(b_track_inverted_pin), 16'(seq[k] == 2'b01));
    end
    chk(16'(up_seen - ub), 16'd3);
    chk(16'(dn_seen - db), 16'd1);
    chk(16'(net_seen - nb), 16'd2);
    chk(16'(dir_faults - fb), 16'd0);
  endtask
  task automatic test_systest;
    set_mode(OMIRM_MODE_SYST);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      probes <= i[3:0];
      idx_raw <= i[0];
      line_count_done <= i[1];
      wait_cyc(1);
      chk(16'(pins), 16'({i[3:0], i[0], i[1]}));
      chk(16'({pin_oe, line_driver_en}), 16'h2);
    end
    @(posedge core_clk);
    idx_raw <= 1'b0;
    line_count_error <= 1'b1;
    idx_enable <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wait_cyc(2);
      chk(16'(fault_pin), 16'h0);
      @(posedge core_clk);
      idx_raw <= 1'b1;
      wait_cyc(2);
      @(posedge core_clk);
      idx_raw <= 1'b0;
    end
    wait_cyc(2);
    chk(16'(fault_pin), 16'h1);
    @(posedge core_clk);
    idx_enable <= 1'b0;
    wait_cyc(3);
    chk(16'(fault_pin), 16'h0);
  endtask
  task automatic test_route;
    logic [7:0] code [6] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h07, 8'hC8};
    logic [11:0] sel [6] = '{12'h99D, 12'h95E, 12'h8EE, 12'h89A, 12'h8AA, 12'h99D};
    for (int k = 0; k < 6; k++) begin
      wr(OMIRM_ADDR_ROUTE, code[k]);
      wait_cyc(2);
      chk(16'({sin_p_sel, sin_n_sel, cos_p_sel, cos_n_sel}), 16'(sel[k]));
      chk(16'({idx_p_sel, idx_n_sel}), (k == 5) ? 16'h11 : 16'h0A);
      rd_chk(OMIRM_ADDR_ROUTE, code[k] & 8'h7F);
    end
  endtask
  task automatic test_load;
    logic [7:0] v [4] = '{8'h06, 8'h09, 8'h41, 8'h0C};
    for (int j = 0; j < 4; j++) begin
      wr(OMIRM_ADDR_IDX, v[j]);
      wr(OMIRM_ADDR_SC, v[3 - j]);
      wait_cyc(2);
      chk(16'({idx_current_mode, idx_res_sel, idx_divider_en, index_ref_level}),
        16'({!v[j][0], v[j][2:1], v[j][0] & v[j][3], v[j][6]}));
      chk(16'({sc_current_mode, sc_res_sel, sc_divider_en, sincos_ref_level}),
        16'({!v[3-j][0], v[3-j][2:1], v[3-j][0] & v[3-j][3], v[3-j][6]}));
      rd_chk(OMIRM_ADDR_IDX, v[j]);
    end
    wr(OMIRM_ADDR_IDX, 8'h49);
    wr(OMIRM_ADDR_SC, 8'h49);
    wait_cyc(2);
    chk(16'({idx_current_mode, idx_res_sel, idx_divider_en, index_ref_level, sc_current_mode,
      sc_res_sel, sc_divider_en, sincos_ref_level}), 16'h063);
  endtask
  task automatic test_cal_check;
    wr(OMIRM_ADDR_SC, 8'h30);
    set_mode(OMIRM_MODE_CAL2);
    chk(16'({potential_to_index, pin_oe, line_driver_en, pins}), 16'h100);
    wr(OMIRM_ADDR_SC, 8'h20);
    wait_cyc(2);
    chk(16'(potential_to_index), 16'h0);
    set_mode(OMIRM_MODE_PINCHK);
    wr(OMIRM_ADDR_ROUTE, 8'(OMIRM_ROUTE_BYPASS));
    wait_cyc(2);
    chk(16'({pin_bypass_en, pin_oe, pins}), 16'h80);
    wr(OMIRM_ADDR_ROUTE, 8'h41);
    wr(OMIRM_ADDR_MODE, 8'h80);
    wr(7'h10, 8'hFF);
    wait_cyc(2);
    chk(16'(pin_bypass_en), 16'h0);
    rd_chk(OMIRM_ADDR_MODE, 8'h06);
    rd_chk(7'h10, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    wait_cyc(10);
    test_reset();
    rst_b <= 1'b1;
    test_quad();
    test_counter();
    test_systest();
    test_route();
    test_load();
    test_cal_check();
    print_verdict();
  end
  initial begin
    #(40 * 20000);
    err_count++;
    print_verdict();
  end
endmodule // omirm_mux_tb
